// File: test/csm_pad_model.sv
// Behavioural sense pad and comparator, the far side of the oscillator input.
// Assumes the bench calls its tasks; levels change just after a clock edge.
`timescale 1ns/100ps
`default_nettype none
module csm_pad_model (
  input wire logic clock_i,
  output logic comp_o
);
  initial comp_o = 1'b0;
  // Emits n rising edges, each level held half clocks (two or more)
  task automatic burst(input int n, input int half);
    repeat (n) begin
      repeat (half) @(posedge clock_i);
      comp_o <= 1'b1;
      repeat (half) @(posedge clock_i);
      comp_o <= 1'b0;
    end
  endtask
  // Parks the comparator at one level
  task automatic hold(input logic lvl);
    @(posedge clock_i);
    comp_o <= lvl;
  endtask
endmodule // csm_pad_model
`default_nettype wire

// File: test/csm_top_tb_top.sv
// Self-checking bench for the sense mode and timer routing block.
// Assumes the block's register map and its one-wait-cycle Avalon bus.
`timescale 1ns/100ps
`default_nettype none
module csm_top_tb_top;
  import csm_pkg::*;
  logic clock_i, rst_i, t1_gate_i, t0_ovf_clr_i, sleep_i, osc_comp_i;
  logic activity_o;
  csm_av_req_t av_req_i;
  csm_av_rsp_t av_rsp_o;
  csm_analog_t analog_o;
  csm_mode_t mode_o;
  int failures = 0;
  int checks = 0;
  int act_n = 0;
  logic [31:0] q, unl, thr;
  csm_mode_t exp_m [8] = '{CSM_OFF, CSM_LO_LOW, CSM_LO_MED, CSM_LO_HIGH,
    CSM_NOISE, CSM_HI_LOW, CSM_HI_MED, CSM_HI_HIGH};

  csm_top u_dut (.clock_i(clock_i), .rst_i(rst_i), .av_req_i(av_req_i),
    .av_rsp_o(av_rsp_o), .osc_comp_i(osc_comp_i), .t1_gate_i(t1_gate_i),
    .t0_ovf_clr_i(t0_ovf_clr_i), .sleep_i(sleep_i), .analog_o(analog_o),
    .mode_o(mode_o), .activity_o(activity_o));
  csm_pad_model u_pad (.clock_i(clock_i), .comp_o(osc_comp_i));

  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    if (activity_o === 1'b1) act_n++;
  end

  task automatic test_done;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  // One Avalon transfer; held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clock_i);
    av_req_i <= '{address: a, read: !w, write: w, writedata: d};
    do begin
      @(posedge clock_i);
      n++;
    end while (av_rsp_o.waitrequest !== 1'b0 && n < 20);
    rd = av_rsp_o.readdata;
    av_req_i <= '0;
    if (n >= 20) begin
      failures++;
      $display("CHECK FAILED t=%0t bus timeout", $time);
      test_done();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [3:0] a);
    bus(1'b0, a, 32'h0, q);
  endtask
  function automatic logic [31:0] ctl(logic r, logic [1:0] p, logic t);
    return {24'h0, 1'b1, r, 2'b00, p, 1'b0, t};
  endfunction
  task automatic cycles(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  // Clears the timer, runs n pad edges, captures the count
  task automatic measure(input logic [3:0] a, input int n, input int half);
    wr(a, 32'h0);
    u_pad.burst(n, half);
    cycles(5);
    rd(a);
  endtask

  initial begin
    av_req_i = '0;
    t1_gate_i = 1'b0;
    t0_ovf_clr_i = 1'b0;
    sleep_i = 1'b0;
    rst_i = 1'b1;
    cycles(5);
    rst_i <= 1'b0;
    rd(A_SENSE_CTRL);
    chk(q, 32'h0);
    chk(32'(mode_o), 32'(CSM_OFF));
    for (int i = 0; i < 8; i++) begin
      wr(A_SENSE_CTRL, ctl(i[2], i[1:0], 1'b0));
      cycles(2);
      chk(32'(mode_o), 32'(exp_m[i]));
      chk(32'(analog_o.ext_ref), 32'(i[2]));
      chk(32'(analog_o.current_level), 32'(i[1:0]));
      chk(32'(analog_o.osc_run), 32'(i != 0));
      if (i[1:0] != 2'b00) chk(32'(analog_o.drive_en), 32'h1);
    end
    wr(A_SENSE_CTRL, ctl(1'b1, 2'b00, 1'b0));
    cycles(2);
    chk(32'(analog_o.drive_en), 32'h0);
    chk(32'(analog_o.osc_run), 32'h1);
    act_n = 0;
    u_pad.burst(6, 2);
    cycles(5);
    chk(32'(act_n), 32'h6);
    rd(A_STATUS);
    chk(q & 32'h3, 32'h1);
    wr(A_STATUS, 32'hFF);
    rd(A_STATUS);
    chk(q & 32'h3, 32'h1);
    rd(4'hF);
    chk(q, UNMAPPED_RD);
    wr(A_CHAN_SEL, 32'h5);
    cycles(2);
    chk(32'(analog_o.chan_en), 32'h020);
    wr(A_CHAN_SEL, 32'h2);
    cycles(2);
    chk(32'(analog_o.chan_en), 32'h004);
    wr(A_CHAN_SEL, 32'hC);
    cycles(2);
    chk(32'(analog_o.chan_en), 32'h0);
    u_pad.hold(1'b1);
    cycles(4);
    rd(A_SENSE_CTRL);
    chk(32'(q[B_OSC_OUT]), 32'h1);
    u_pad.hold(1'b0);
    cycles(4);
    rd(A_SENSE_CTRL);
    chk(32'(q[B_OSC_OUT]), 32'h0);
    wr(A_SENSE_CTRL, ctl(1'b0, 2'b11, 1'b0));
    wr(A_T1_CTRL, 32'hC1);
    measure(A_TMR1, 20, 2);
    unl = q;
    chk(32'(q[15:0]), 32'd20);
    measure(A_TMR1, 8, 5);
    chk(32'(q[15:0]), 32'd8);
    chk(32'(q < unl), 32'h1);
    // Both windows span 80 clocks: 20 edges of 4 clocks, 8 edges of 10
    chk(unl * 32'h4, 32'h50);
    chk(q * 32'hA, 32'h50);
    thr = (unl + q) >> 1;
    chk(32'((q < thr) && (thr < unl)), 32'h1);
    wr(A_T1_CTRL, 32'hC2);
    measure(A_TMR1, 4, 2);
    chk(32'(q[15:0]), 32'd0);
    wr(A_T1_CTRL, 32'hC3);
    measure(A_TMR1, 4, 2);
    chk(32'(q[15:0]), 32'd0);
    t1_gate_i <= 1'b1;
    cycles(3);
    measure(A_TMR1, 4, 2);
    chk(32'(q[15:0]), 32'd4);
    wr(A_SENSE_CTRL, ctl(1'b0, 2'b11, 1'b1));
    wr(A_T0_CTRL, 32'h0);
    measure(A_TMR0, 5, 2);
    chk(32'(q[7:0]), 32'd5);
    wr(A_T0_CTRL, 32'h1);
    measure(A_TMR0, 3, 2);
    chk(32'(q[7:0]), 32'd0);
    wr(A_T0_CTRL, 32'h0);
    wr(A_T1_CTRL, 32'hC1);
    wr(A_TMR0, 32'h0);
    wr(A_TMR1, 32'h0);
    sleep_i <= 1'b1;
    u_pad.burst(5, 2);
    cycles(5);
    sleep_i <= 1'b0;
    rd(A_TMR0);
    chk(32'(q[7:0]), 32'd0);
    rd(A_TMR1);
    chk(32'(q[15:0]), 32'd5);
    measure(A_TMR0, 0, 2);
    wr(A_TMR0, 32'hFE);
    u_pad.burst(2, 2);
    cycles(5);
    rd(A_STATUS);
    chk(32'(q[B_ST_T0OVF]), 32'h1);
    rd(A_TMR0);
    chk(32'(q[7:0]), 32'h0);
    t0_ovf_clr_i <= 1'b1;
    cycles(1);
    t0_ovf_clr_i <= 1'b0;
    rd(A_STATUS);
    chk(32'(q[B_ST_T0OVF]), 32'h0);
    test_done();
  end
endmodule // csm_top_tb_top
`default_nettype wire

// File: verilog/csm_edge_sync.sv
// Two flip-flop synchroniser with rising edge pulse on the synchronised side.
// Assumes the input is asynchronous to clock_i.
`timescale 1ns/100ps
`default_nettype none
module csm_edge_sync (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic async_i,
  output logic level_o,
  output logic rise_o
);
  logic meta;
  logic sync;
  logic prev;

  // First stage feeds only the second
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      meta <= 1'b0;
      sync <= 1'b0;
    end else begin
      meta <= async_i;
      sync <= meta;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      prev <= 1'b0;
    end else begin
      prev <= sync;
    end
  end

  assign level_o = sync;
  assign rise_o = sync & ~prev; // see RULE17
endmodule // csm_edge_sync
`default_nettype wire

// File: verilog/csm_pkg.sv
// Constants, register map and types for the capacitive sense mode and timer
// routing block. Assumes one 200 MHz clock and a synchronous reset.
// How it works
// RULE1 - Power code 00 off, else low/medium/high
// RULE2 - Range bit 0 internal, 1 external references
// RULE3 - High range code 00 is noise detection
// RULE4 - Noise drives oscillator; comparator output toggles
// RULE5 - Select set, clock bit clear: timer zero counts
// RULE6 - Timer one source field 11 counts oscillator edges
// RULE7 - Timer one: off, free running, or gated count
// RULE8 - Time base never from the counting timer
// RULE9 - Software clears timer, then captures count
// RULE10 - Frequency equals count over time base period
// RULE11 - Time base from timer zero overflow, gate toggle
// RULE12 - Loaded measurement uses same time base
// RULE13 - Threshold midway between unloaded and loaded
// RULE14 - Read-only status shows sink or source
// RULE15 - Selected channel pin gets the oscillator
// RULE16 - Timer zero halts during sleep
// RULE17 - Oscillator synchronised; one count per edge
package csm_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int TMR0_W = 8;
  localparam int TMR1_W = 16;
  localparam int CHAN_W = 4;
  localparam int NUM_CHAN = 12;
  // Register word addresses
  localparam logic [ADDR_W-1:0] A_SENSE_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] A_CHAN_SEL = 4'h1;
  localparam logic [ADDR_W-1:0] A_T0_CTRL = 4'h2;
  localparam logic [ADDR_W-1:0] A_T1_CTRL = 4'h3;
  localparam logic [ADDR_W-1:0] A_TMR0 = 4'h4;
  localparam logic [ADDR_W-1:0] A_TMR1 = 4'h5;
  localparam logic [ADDR_W-1:0] A_STATUS = 4'h6;
  // Sense control field positions
  localparam int B_ENABLE = 7;
  localparam int B_RANGE = 6;
  localparam int B_PWR_HI = 3;
  localparam int B_PWR_LO = 2;
  localparam int B_OSC_OUT = 1;
  localparam int B_T0_SENSE = 0;
  // Timer controls
  localparam int B_T0_CS = 0;
  localparam int B_T1_ON = 0;
  localparam int B_T1_GE = 1;
  localparam int B_T1_CS_LO = 6;
  localparam int B_T1_CS_HI = 7;
  // Status bits
  localparam int B_ST_NOISE = 0;
  localparam int B_ST_DRIVE = 1;
  localparam int B_ST_T0OVF = 2;
  localparam logic [1:0] PWR_OFF = 2'h0;
  localparam logic [1:0] PWR_LOW = 2'h1;
  localparam logic [1:0] PWR_MED = 2'h2;
  localparam logic [1:0] PWR_HIGH = 2'h3;
  localparam logic [1:0] T1_SRC_SENSE = 2'h3;
  localparam logic RANGE_LOW = 1'b0;
  localparam logic RANGE_HIGH = 1'b1;
  localparam logic [DATA_W-1:0] UNMAPPED_RD = 32'h0;

  typedef enum {
    CSM_OFF, CSM_LO_LOW, CSM_LO_MED, CSM_LO_HIGH,
    CSM_NOISE, CSM_HI_LOW, CSM_HI_MED, CSM_HI_HIGH
  } csm_mode_t;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [DATA_W-1:0] writedata;
  } csm_av_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] readdata;
    logic waitrequest;
  } csm_av_rsp_t;

  // Analog controls toward the oscillator
  typedef struct packed {
    logic osc_run;
    logic drive_en;
    logic ext_ref;
    logic [1:0] current_level;
    logic [NUM_CHAN-1:0] chan_en;
  } csm_analog_t;
endpackage : csm_pkg

// File: verilog/csm_top.sv
// Capacitive sense mode decode, timer routing and Avalon-MM register slave.
// Assumes oscillator and gate inputs come from analog or pin logic.
`timescale 1ns/100ps
`default_nettype none
module csm_top (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire csm_pkg::csm_av_req_t av_req_i,
  output csm_pkg::csm_av_rsp_t av_rsp_o,
  input wire logic osc_comp_i,
  input wire logic t1_gate_i,
  input wire logic t0_ovf_clr_i,
  input wire logic sleep_i,
  output csm_pkg::csm_analog_t analog_o,
  output csm_pkg::csm_mode_t mode_o,
  output logic activity_o
);
  import csm_pkg::*;

  logic sense_enable;
  logic sense_range_select;
  logic [1:0] sense_power_level;
  logic timer_zero_sense_source_sel;
  logic timer_zero_clock_source_bit;
  logic timer_one_on_bit;
  logic timer_one_gate_enable;
  logic [1:0] timer_one_clock_source_field;
  logic [CHAN_W-1:0] sense_channel_sel;
  logic [TMR0_W-1:0] timer_zero;
  logic [TMR1_W-1:0] timer_one;
  logic t0_ovf;
  logic ack;
  logic osc_level;
  logic osc_rise;
  logic t0_tick;
  logic t1_tick;
  logic t1_run;
  logic wr_hit;
  logic rd_hit;
  csm_mode_t next_mode;
  csm_analog_t next_analog;

  function automatic logic hit(input csm_av_req_t r, input logic [ADDR_W-1:0] a,
                               input logic wr);
    hit = (wr ? r.write : r.read) && (r.address == a);
  endfunction

  csm_edge_sync u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .async_i(osc_comp_i),
    .level_o(osc_level),
    .rise_o(osc_rise)
  );

  // One wait state: ack goes high the cycle after the request appears
  assign wr_hit = av_req_i.write & ack;
  assign rd_hit = av_req_i.read & ack;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ack <= 1'b0;
    end else begin
      ack <= (av_req_i.read | av_req_i.write) & ~ack;
    end
  end

  // Control registers
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sense_enable <= 1'b0;
      sense_range_select <= RANGE_LOW;
      sense_power_level <= PWR_OFF;
      timer_zero_sense_source_sel <= 1'b0;
      timer_zero_clock_source_bit <= 1'b0;
      timer_one_on_bit <= 1'b0;
      timer_one_gate_enable <= 1'b0;
      timer_one_clock_source_field <= 2'h0;
      sense_channel_sel <= 4'h0;
    end else begin
      if (wr_hit && hit(av_req_i, A_SENSE_CTRL, 1'b1)) begin
        sense_enable <= av_req_i.writedata[B_ENABLE];
        sense_range_select <= av_req_i.writedata[B_RANGE];
        sense_power_level <= av_req_i.writedata[B_PWR_HI:B_PWR_LO];
        timer_zero_sense_source_sel <= av_req_i.writedata[B_T0_SENSE];
      end
      if (wr_hit && hit(av_req_i, A_CHAN_SEL, 1'b1)) begin
        sense_channel_sel <= av_req_i.writedata[CHAN_W-1:0];
      end
      if (wr_hit && hit(av_req_i, A_T0_CTRL, 1'b1)) begin
        timer_zero_clock_source_bit <= av_req_i.writedata[B_T0_CS];
      end
      if (wr_hit && hit(av_req_i, A_T1_CTRL, 1'b1)) begin
        timer_one_on_bit <= av_req_i.writedata[B_T1_ON];
        timer_one_gate_enable <= av_req_i.writedata[B_T1_GE];
        timer_one_clock_source_field <= av_req_i.writedata[B_T1_CS_HI:B_T1_CS_LO];
      end
    end
  end

  // Timer sources and enables
  assign t0_tick = timer_zero_sense_source_sel & ~timer_zero_clock_source_bit
                   & osc_rise & ~sleep_i; // see RULE5 see RULE16
  assign t1_run = timer_one_on_bit & (~timer_one_gate_enable | t1_gate_i); // see RULE7
  assign t1_tick = (timer_one_clock_source_field == T1_SRC_SENSE)
                   & osc_rise & t1_run; // see RULE6

  // Timer 0: software write clears or loads it
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      timer_zero <= 8'h00;
    end else if (wr_hit && hit(av_req_i, A_TMR0, 1'b1)) begin
      timer_zero <= av_req_i.writedata[TMR0_W-1:0];
    end else if (t0_tick) begin
      timer_zero <= timer_zero + 8'h01; // see RULE17
    end
  end

  // Overflow flag: set wins over clear
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      t0_ovf <= 1'b0;
    end else if (t0_tick && (timer_zero == 8'hFF)) begin
      t0_ovf <= 1'b1;
    end else if (t0_ovf_clr_i) begin
      t0_ovf <= 1'b0;
    end
  end

  // Timer 1
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      timer_one <= 16'h0000;
    end else if (wr_hit && hit(av_req_i, A_TMR1, 1'b1)) begin
      timer_one <= av_req_i.writedata[TMR1_W-1:0];
    end else if (t1_tick) begin
      timer_one <= timer_one + 16'h0001; // see RULE17
    end
  end

  // Power mode decode
  always_comb begin
    next_mode = CSM_OFF;
    if (!sense_enable) begin
      next_mode = CSM_OFF;
    end else if (sense_range_select == RANGE_HIGH) begin // see RULE2
      case (sense_power_level) // see RULE1
        PWR_OFF: next_mode = CSM_NOISE; // see RULE3
        PWR_LOW: next_mode = CSM_HI_LOW;
        PWR_MED: next_mode = CSM_HI_MED;
        PWR_HIGH: next_mode = CSM_HI_HIGH;
        default: next_mode = CSM_OFF;
      endcase
    end else begin
      case (sense_power_level) // see RULE1
        PWR_OFF: next_mode = CSM_OFF;
        PWR_LOW: next_mode = CSM_LO_LOW;
        PWR_MED: next_mode = CSM_LO_MED;
        PWR_HIGH: next_mode = CSM_LO_HIGH;
        default: next_mode = CSM_OFF;
      endcase
    end
  end

  // Analog controls
  always_comb begin
    next_analog = '0;
    next_analog.osc_run = (next_mode != CSM_OFF);
    next_analog.drive_en = (next_mode != CSM_OFF)
                           && (next_mode != CSM_NOISE); // see RULE3
    next_analog.ext_ref = sense_range_select; // see RULE2
    next_analog.current_level = sense_power_level;
    if (sense_enable && (sense_channel_sel < NUM_CHAN)) begin
      next_analog.chan_en[sense_channel_sel] = 1'b1; // see RULE15
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      mode_o <= CSM_OFF;
      analog_o <= '0;
      activity_o <= 1'b0;
    end else begin
      mode_o <= next_mode;
      analog_o <= next_analog;
      activity_o <= (mode_o == CSM_NOISE) & osc_rise; // see RULE4
    end
  end

  // Read data and waitrequest
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      av_rsp_o <= '{readdata: UNMAPPED_RD, waitrequest: 1'b1};
    end else begin
      av_rsp_o.waitrequest <= ~((av_req_i.read | av_req_i.write) & ~ack);
      av_rsp_o.readdata <= UNMAPPED_RD;
      if (av_req_i.read && !ack) begin
        case (av_req_i.address)
          A_SENSE_CTRL: begin
            av_rsp_o.readdata[B_ENABLE] <= sense_enable;
            av_rsp_o.readdata[B_RANGE] <= sense_range_select;
            av_rsp_o.readdata[B_PWR_HI:B_PWR_LO] <= sense_power_level;
            av_rsp_o.readdata[B_OSC_OUT] <= osc_level; // see RULE14
            av_rsp_o.readdata[B_T0_SENSE] <= timer_zero_sense_source_sel;
          end
          A_CHAN_SEL: av_rsp_o.readdata[CHAN_W-1:0] <= sense_channel_sel;
          A_T0_CTRL: av_rsp_o.readdata[B_T0_CS] <= timer_zero_clock_source_bit;
          A_T1_CTRL: begin
            av_rsp_o.readdata[B_T1_ON] <= timer_one_on_bit;
            av_rsp_o.readdata[B_T1_GE] <= timer_one_gate_enable;
            av_rsp_o.readdata[B_T1_CS_HI:B_T1_CS_LO] <=
              timer_one_clock_source_field;
          end
          A_TMR0: av_rsp_o.readdata[TMR0_W-1:0] <= timer_zero;
          A_TMR1: av_rsp_o.readdata[TMR1_W-1:0] <= timer_one;
          A_STATUS: begin
            av_rsp_o.readdata[B_ST_NOISE] <= (mode_o == CSM_NOISE);
            av_rsp_o.readdata[B_ST_DRIVE] <= analog_o.drive_en;
            av_rsp_o.readdata[B_ST_T0OVF] <= t0_ovf;
          end
          default: av_rsp_o.readdata <= UNMAPPED_RD;
        endcase
      end
    end
  end

  a_t1_off_hold: assert property (@(posedge clock_i) disable iff (rst_i)
    !timer_one_on_bit && !(av_req_i.write && ack)
    |=> timer_one == $past(timer_one)) // see RULE7
    else $error("timer one moved while off");
  a_noise_no_drive: assert property (@(posedge clock_i) disable iff (rst_i)
    sense_enable && sense_range_select && sense_power_level == PWR_OFF
    |=> mode_o == CSM_NOISE && !analog_o.drive_en) // see RULE3
    else $error("noise mode not entered");
  a_low_off: assert property (@(posedge clock_i) disable iff (rst_i)
    sense_enable && !sense_range_select && sense_power_level == PWR_OFF
    |=> mode_o == CSM_OFF && !analog_o.ext_ref) // see RULE1
    else $error("low range off decode wrong");
  a_hi_high: assert property (@(posedge clock_i) disable iff (rst_i)
    sense_enable && sense_range_select && sense_power_level == PWR_HIGH
    |=> mode_o == CSM_HI_HIGH && analog_o.ext_ref) // see RULE2
    else $error("high range high decode wrong");
  a_t0_sense_count: assert property (@(posedge clock_i) disable iff (rst_i)
    t0_tick && !(av_req_i.write && ack)
    |=> timer_zero == $past(timer_zero) + 8'h01) // see RULE5
    else $error("timer zero missed an edge");
  a_t0_sleep_hold: assert property (@(posedge clock_i) disable iff (rst_i)
    sleep_i && !(av_req_i.write && ack)
    |=> timer_zero == $past(timer_zero)) // see RULE16
    else $error("timer zero counted in sleep");
  a_t1_sense_count: assert property (@(posedge clock_i) disable iff (rst_i)
    timer_one_clock_source_field == T1_SRC_SENSE && timer_one_on_bit
    && !timer_one_gate_enable && osc_rise && !(av_req_i.write && ack)
    |=> timer_one == $past(timer_one) + 16'h0001) // see RULE6
    else $error("timer one missed an edge");
  a_single_tick: assert property (@(posedge clock_i) disable iff (rst_i)
    osc_rise |=> !osc_rise) // see RULE17
    else $error("one edge counted twice");
  a_chan_route: assert property (@(posedge clock_i) disable iff (rst_i)
    sense_enable && sense_channel_sel == 4'h2
    |=> analog_o.chan_en[2]) // see RULE15
    else $error("channel not routed");
  a_status_rd: assert property (@(posedge clock_i) disable iff (rst_i)
    av_req_i.read && !ack && av_req_i.address == A_SENSE_CTRL
    |=> av_rsp_o.readdata[B_OSC_OUT] == $past(osc_level)) // see RULE14
    else $error("oscillator status wrong");
endmodule // csm_top
`default_nettype wire
